// ---- rtl/aw_queue_read_side.sv ----
// Write-address queue with AXI read side, fill counts, flags and SECDED
// Notes on behaviour
// - Valid high while an entry is shown; payload held until ready seen high.
// - Cache, protection, QoS, region and user bits travel with every address.
// - Almost-full threshold comes from an input, taken on the first edge after reset release.
// - Almost-empty threshold comes from an input, taken on the first edge after reset release.
// - With ECC on, single injection flips one bit of the stored word.
// - With ECC on, double injection flips two bits of the stored word.
// - Decoder flags a one-bit error and delivers corrected data.
// - Decoder flags a two-bit error as uncorrectable.
// - Overflow high cycle after a write refused when full; contents untouched.
// - Writes are blocked once full, but a write offered then still raises overflow.
// - Underflow stays low: a read when empty pops nothing and is never flagged; contents untouched.
// - Reads are blocked once empty, so underflow may stay zero.
// - Write-side fill never under-reports the words held.
// - A write shows in write-side fill from the next edge on.
// - Read-side fill never over-reports the readable words.
// - A read shows in read-side fill from the next edge on.
// - Common fill equals the number of words held.
// - Almost-full high while count at or above threshold, low below.
// - Almost-empty high while count at or below threshold, low above.
`timescale 1ns/1ps
module aw_queue_read_side
  import aw_queue_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Upstream side, joined to the slave-channel logic
  input  wire logic               wrValid,
  input  wire aw_payload_t        wrData,
  output logic                    wrReady,
  // Downstream AXI write address channel
  output logic                    mAwValid,
  input  wire logic               mAwReady,
  output aw_payload_t             mAw,
  // Sideband
  input  wire logic [THR_W-1:0]   almostFullThr,
  input  wire logic [THR_W-1:0]   almostEmptyThr,
  input  wire logic               injectSingleErr,
  input  wire logic               injectDoubleErr,
  output logic                    singleErr,
  output logic                    doubleErr,
  output logic                    addr_queue_write_refused,
  output logic                    addr_queue_read_refused,
  output logic [COUNT_W-1:0]      addr_queue_write_side_fill,
  output logic [COUNT_W-1:0]      addr_queue_read_side_fill,
  output logic [COUNT_W-1:0]      addr_queue_common_fill,
  output logic                    addr_queue_almost_full_flag,
  output logic                    addr_queue_almost_empty_flag,
  // Avalon-MM register slave
  input  wire logic [3:0]         avsAddress,
  input  wire logic               avsRead,
  input  wire logic               avsWrite,
  input  wire logic [31:0]        avsWritedata,
  output logic [31:0]             avsReaddata,
  output logic                    avsWaitrequest
);

  // ---------------------------------------------------------------
  // SECDED helpers
  // ---------------------------------------------------------------
  function automatic code_t eccEncode(aw_payload_t d);
    code_t             c;
    int                k;
    logic [PAR_N-1:0]  par;
    c   = '0;
    k   = 0;
    par = '0;
    for (int p = 1; p < CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k    = k + 1;
      end
    end
    for (int p = 1; p < CODE_W; p++) begin
      if (c[p]) begin
        par = par ^ PAR_N'(p);
      end
    end
    for (int i = 0; i < PAR_N; i++) begin
      c[2 ** i] = par[i];
    end
    c[0] = ^c[CODE_W-1:1];
    return c;
  endfunction

  function automatic ecc_result_t eccDecode(code_t cIn, logic en);
    ecc_result_t       r;
    code_t             c;
    logic [PAR_N-1:0]  syn;
    logic              allPar;
    int                k;
    c      = cIn;
    syn    = '0;
    k      = 0;
    r      = '0;
    allPar = ^cIn;
    for (int p = 1; p < CODE_W; p++) begin
      if (c[p]) begin
        syn = syn ^ PAR_N'(p);
      end
    end
    if (en) begin
      if (allPar) begin
        r.single = 1'b1;
        if ((syn != '0) && (int'(syn) < CODE_W)) begin
          c[syn] = ~c[syn];
        end
      end else if (syn != '0) begin
        r.double = 1'b1;
      end
    end
    for (int p = 1; p < CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        r.data[k] = c[p];
        k         = k + 1;
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------
  code_t              mem [DEPTH];
  logic [ADDR_W-1:0]  wrPtr_q;
  logic [ADDR_W-1:0]  rdPtr_q;
  logic [COUNT_W-1:0] memCount_q;
  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic               outValid_q;
  aw_payload_t        outData_q;
  logic               sbErr_q;
  logic               dbErr_q;
  logic               eccEn_q;
  logic               push;
  logic               pop;
  logic               load;
  code_t              wrCode;
  ecc_result_t        rdRes;

  // Full counts the word in the output stage, so at most DEPTH are held
  assign wrReady  = (count_q != COUNT_W'(DEPTH));
  assign push     = wrValid && wrReady;
  assign pop      = outValid_q && mAwReady;
  assign load     = (memCount_q != '0) && (!outValid_q || pop);
  assign mAwValid = outValid_q;
  assign mAw      = outData_q;
  assign rdRes    = eccDecode(mem[rdPtr_q], eccEn_q);

  // Data positions are hit, so a missing correction shows on the output
  always_comb begin
    wrCode = eccEncode(wrData);
    if (eccEn_q && injectDoubleErr) begin
      wrCode[3] = ~wrCode[3];
      wrCode[5] = ~wrCode[5];
    end else if (eccEn_q && injectSingleErr) begin
      wrCode[3] = ~wrCode[3];
    end
  end

  // Memory has no reset; only pushed entries are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q] <= wrCode;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
    end else if (push) begin
      wrPtr_q <= wrPtr_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPtr_q <= '0;
    end else if (load) begin
      rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memCount_q <= '0;
    end else begin
      memCount_q <= memCount_q + COUNT_W'(push) - COUNT_W'(load);
    end
  end

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      outValid_q <= 1'b0;
      outData_q  <= '0;
      sbErr_q    <= 1'b0;
      dbErr_q    <= 1'b0;
    end else if (load) begin
      outValid_q <= 1'b1;
      outData_q  <= rdRes.data;
      sbErr_q    <= rdRes.single;
      dbErr_q    <= rdRes.double;
    end else if (pop) begin
      outValid_q <= 1'b0;
      sbErr_q    <= 1'b0;
      dbErr_q    <= 1'b0;
    end
  end

  assign singleErr = sbErr_q;
  assign doubleErr = dbErr_q;

  // ---------------------------------------------------------------
  // Fill counts and flags
  // ---------------------------------------------------------------
  assign count_d = count_q + COUNT_W'(push) - COUNT_W'(pop);

  // One clock: every count is exact and lags its event by one edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign addr_queue_write_side_fill = count_q;
  assign addr_queue_read_side_fill  = count_q;
  assign addr_queue_common_fill     = count_q;

  // ---------------------------------------------------------------
  // Thresholds
  // ---------------------------------------------------------------

  logic [THR_W-1:0] afThr_q;
  logic [THR_W-1:0] aeThr_q;
  logic             thrTaken_q;

  // Thresholds are sampled on the first edge after reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      afThr_q    <= AF_THR_RESET;
      aeThr_q    <= AE_THR_RESET;
      thrTaken_q <= 1'b0;
    end else if (!thrTaken_q) begin
      afThr_q    <= almostFullThr;
      aeThr_q    <= almostEmptyThr;
      thrTaken_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Almost flags
  // ---------------------------------------------------------------

  logic afFlag_q;
  logic aeFlag_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      afFlag_q <= 1'b0;
      aeFlag_q <= 1'b1;
    end else begin
      afFlag_q <= (count_d >= COUNT_W'(afThr_q));
      aeFlag_q <= (count_d <= COUNT_W'(aeThr_q));
    end
  end

  assign addr_queue_almost_full_flag  = afFlag_q;
  assign addr_queue_almost_empty_flag = aeFlag_q;

  // ---------------------------------------------------------------
  // Refusal flags
  // ---------------------------------------------------------------

  logic ovf_q;
  logic unf_q;

  // Read side only pops on a valid handshake, so a refused read cannot occur
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      ovf_q <= wrValid && !wrReady;
      unf_q <= pop && !outValid_q;
    end
  end

  assign addr_queue_write_refused = ovf_q;
  assign addr_queue_read_refused  = unf_q;

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  bus_state_t  busState_q;
  logic [31:0] rdData_q;
  logic [1:0]  errSticky_q;
  logic        busReq;
  logic        wrTake;

  assign busReq         = avsRead || avsWrite;
  assign avsWaitrequest = busReq && (busState_q == BUS_IDLE);
  assign wrTake         = avsWrite && (busState_q == BUS_ACK);
  assign avsReaddata    = rdData_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busState_q <= BUS_IDLE;
    end else begin
      case (busState_q)
        BUS_IDLE: begin
          if (busReq) begin
            busState_q <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          busState_q <= BUS_IDLE;
        end
        default: begin
          busState_q <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= '0;
    end else if (avsRead && (busState_q == BUS_IDLE)) begin
      if (avsAddress == REG_CTRL) begin
        rdData_q <= {31'h0, eccEn_q};
      end else if (avsAddress == REG_STATUS) begin
        rdData_q <= {20'h0, unf_q, ovf_q, aeFlag_q, afFlag_q, 3'h0, count_q};
      end else if (avsAddress == REG_ERRORS) begin
        rdData_q <= {30'h0, errSticky_q};
      end else begin
        rdData_q <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eccEn_q <= ECC_EN_RESET;
    end else if (wrTake && (avsAddress == REG_CTRL)) begin
      eccEn_q <= avsWritedata[CTRL_ECC_BIT];
    end
  end

  // Write one to clear; a new error in the same cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      errSticky_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wrTake && (avsAddress == REG_ERRORS) && avsWritedata[i]) begin
          errSticky_q[i] <= 1'b0;
        end
      end
      if (load && rdRes.single) begin
        errSticky_q[ERR_SINGLE_BIT] <= 1'b1;
      end
      if (load && rdRes.double) begin
        errSticky_q[ERR_DOUBLE_BIT] <= 1'b1;
      end
    end
  end

endmodule

// ---- rtl/aw_queue_pkg.sv ----
// Shared constants and types for the write-address queue read side
package aw_queue_pkg;

  // ---------------------------------------------------------------
  // Queue geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 4;
  localparam int DEPTH   = 16;
  localparam int COUNT_W = ADDR_W + 1;
  localparam int THR_W   = ADDR_W;

  // ---------------------------------------------------------------
  // Payload carried per address transfer
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  id;
    logic [31:0] addr;
    logic [7:0]  len;
    logic [2:0]  size;
    logic [1:0]  burst;
    logic        lock;
    logic [3:0]  cache;
    logic [2:0]  prot;
    logic [3:0]  qos;
    logic [3:0]  region;
    logic        user;
  } aw_payload_t;

  localparam int DATA_W = $bits(aw_payload_t);
  localparam int PAR_N  = 7;
  localparam int CODE_W = DATA_W + PAR_N + 1;

  typedef logic [CODE_W-1:0] code_t;

  typedef struct packed {
    aw_payload_t data;
    logic        single;
    logic        double;
  } ecc_result_t;

  // ---------------------------------------------------------------
  // Register bus map (byte addresses) and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ERRORS = 4'h8;

  localparam int CTRL_ECC_BIT   = 0;
  localparam int ERR_SINGLE_BIT = 0;
  localparam int ERR_DOUBLE_BIT = 1;
  localparam int STAT_AF_BIT    = 8;
  localparam int STAT_AE_BIT    = 9;
  localparam int STAT_OVF_BIT   = 10;
  localparam int STAT_UNF_BIT   = 11;

  localparam logic             ECC_EN_RESET = 1'b1;
  localparam logic [THR_W-1:0] AF_THR_RESET = 4'hE;
  localparam logic [THR_W-1:0] AE_THR_RESET = 4'h1;

  // ---------------------------------------------------------------
  // Avalon slave states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage

// ---- testbench/aw_sink.sv ----
// Downstream address sink model with stall control
`timescale 1ns/1ps
module aw_sink
  import aw_queue_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Address channel
  input  wire logic        mAwValid,
  input  wire aw_payload_t mAw,
  output logic             mAwReady,
  // Control and capture
  input  wire logic        stall,
  output logic [7:0]       nTaken
);
  // Ready is a level, low only while the bench stalls
  assign mAwReady = !stall;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nTaken <= 8'h00;
    end else if (mAwValid && mAwReady) begin
      nTaken <= nTaken + 8'h01;
    end
  end
endmodule

// ---- testbench/aw_queue_read_side_asserts.sv ----
// Port checker for the write-address queue read side
`timescale 1ns/1ps
module aw_queue_read_side_asserts
  import aw_queue_pkg::*;
(
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rst_n,
  // Streams
  input wire logic               wrValid,
  input wire logic               wrReady,
  input wire logic               mAwValid,
  input wire logic               mAwReady,
  input wire aw_payload_t        mAw,
  // Sideband
  input wire logic [THR_W-1:0]   almostFullThr,
  input wire logic [THR_W-1:0]   almostEmptyThr,
  input wire logic               singleErr,
  input wire logic               doubleErr,
  input wire logic               addr_queue_write_refused,
  input wire logic               addr_queue_read_refused,
  input wire logic [COUNT_W-1:0] addr_queue_write_side_fill,
  input wire logic [COUNT_W-1:0] addr_queue_read_side_fill,
  input wire logic [COUNT_W-1:0] addr_queue_common_fill,
  input wire logic               addr_queue_almost_full_flag,
  input wire logic               addr_queue_almost_empty_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  hold_payload_a: assert property (mAwValid && !mAwReady |=> mAwValid && $stable(mAw) && $stable(singleErr))
    else $error("payload moved while stalled");
  pop_count_a: assert property (mAwValid && mAwReady && !(wrValid && wrReady)
    |=> addr_queue_read_side_fill == $past(addr_queue_read_side_fill) - 5'h01) else $error("pop not counted");
  push_count_a: assert property (wrValid && wrReady && !(mAwValid && mAwReady)
    |=> addr_queue_write_side_fill == $past(addr_queue_write_side_fill) + 5'h01) else $error("push not counted");
  refuse_flag_a: assert property (wrValid && !wrReady && !mAwReady
    |=> addr_queue_write_refused && addr_queue_common_fill == 5'h10 && $stable(mAw)) else $error("refusal wrong");
  no_underflow_a: assert property (!addr_queue_read_refused)
    else $error("underflow raised");
  fill_match_a: assert property (addr_queue_read_side_fill == addr_queue_common_fill
    && addr_queue_write_side_fill == addr_queue_common_fill) else $error("fill counts differ");
  full_ready_a: assert property (wrReady == (addr_queue_common_fill != 5'h10))
    else $error("ready not tied to full");
  almost_full_a: assert property ($stable(addr_queue_common_fill) |->
    addr_queue_almost_full_flag == (addr_queue_common_fill >= {1'b0, almostFullThr})) else $error("almost full wrong");
  almost_empty_a: assert property ($stable(addr_queue_common_fill) |->
    addr_queue_almost_empty_flag == (addr_queue_common_fill <= {1'b0, almostEmptyThr})) else $error("almost empty wrong");
  ecc_valid_a: assert property (singleErr || doubleErr |-> mAwValid)
    else $error("error flag without word");
endmodule

// ---- testbench/tb_aw_queue_read_side.sv ----
// Self-checking bench for the write-address queue read side
`timescale 1ns/1ps
module tb_aw_queue_read_side;
  import aw_queue_pkg::*;
  typedef struct packed {
    aw_payload_t    p;
    logic [4:0]     fill;
    logic           af;
    logic           ae;
  } row_t;
  logic ref_clk = 1'b0, rst_n = 1'b0, wrValid = 1'b0, injS = 1'b0, injD = 1'b0, stall = 1'b1;
  logic avsRead = 1'b0, avsWrite = 1'b0, wrReady, mAwValid, mAwReady, singleErr, doubleErr, wRef, rRef;
  logic af, ae, avsWaitrequest;
  logic [3:0] avsAddress = 4'h0, afThr = 4'h8, aeThr = 4'h3;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, q;
  logic [4:0] wFill, rFill, cFill;
  logic [7:0] nTaken;
  aw_payload_t wrData = '0, mAw;
  row_t rows [16];
  int miscompares = 0, nChecks = 0;

  always #20 ref_clk = ~ref_clk;

  aw_queue_read_side aw_queue_read_side_i (.ref_clk, .rst_n, .wrValid, .wrData, .wrReady, .mAwValid, .mAwReady,
    .mAw, .almostFullThr(afThr), .almostEmptyThr(aeThr), .injectSingleErr(injS), .injectDoubleErr(injD),
    .singleErr, .doubleErr, .addr_queue_write_refused(wRef), .addr_queue_read_refused(rRef),
    .addr_queue_write_side_fill(wFill), .addr_queue_read_side_fill(rFill), .addr_queue_common_fill(cFill),
    .addr_queue_almost_full_flag(af), .addr_queue_almost_empty_flag(ae), .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsReaddata, .avsWaitrequest);
  aw_sink aw_sink_i (.ref_clk, .rst_n, .mAwValid, .mAw, .mAwReady, .stall, .nTaken);

  task automatic check(input string nm, input logic [65:0] seen, input logic [65:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    // Read right after the edge: the values the slave sampled there
    do begin
      @(posedge ref_clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    // Idle edge so a following call never re-raises in this time step
    @(posedge ref_clk);
  endtask

  // Push one word, then settle two cycles so registered flags catch up
  task automatic push(input aw_payload_t p, input logic s, input logic d);
    wrValid <= 1'b1;
    wrData <= p;
    injS <= s;
    injD <= d;
    @(posedge ref_clk);
    wrValid <= 1'b0;
    injS <= 1'b0;
    injD <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic pop();
    stall <= 1'b0;
    @(posedge ref_clk);
    stall <= 1'b1;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    for (int i = 0; i < 16; i++) begin
      rows[i].p = {i[3:0], 32'h1000_0000 + 32'(i * 4), 8'(i), 3'h2, 2'h1, i[0], i[3:0], i[2:0], ~i[3:0], i[3:0], i[1]};
      rows[i].fill = 5'(i + 1);
      rows[i].af = (i + 1 >= 8);
      rows[i].ae = (i + 1 <= 3);
    end
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    check("fill", cFill, 5'h00);
    check("empty", ae, 1'b1);
    check("valid", mAwValid, 1'b0);
    @(posedge ref_clk);
    avs(1'b0, REG_CTRL, 32'h0);
    check("ctrl", q, {31'h0, ECC_EN_RESET});
    avs(1'b1, 4'hC, 32'hFFFF_FFFF);
    avs(1'b0, 4'hC, 32'h0);
    check("unmapped", q, 32'h0);
    for (int i = 0; i < 16; i++) begin
      push(rows[i].p, 1'b0, 1'b0);
      check("fill", wFill, rows[i].fill);
      check("afull", af, rows[i].af);
      check("aempty", ae, rows[i].ae);
      @(posedge ref_clk);
    end
    avs(1'b0, REG_STATUS, 32'h0);
    check("status", q[8:0], 9'h110);
    wrValid <= 1'b1;
    wrData <= '1;
    @(posedge ref_clk);
    wrValid <= 1'b0;
    @(negedge ref_clk);
    check("refused", wRef, 1'b1);
    check("full", wrReady, 1'b0);
    check("fill", rFill, 5'h10);
    @(negedge ref_clk);
    check("refusedEnd", wRef, 1'b0);
    @(posedge ref_clk);
    stall <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(negedge ref_clk);
      check("payload", mAw, rows[i].p);
      @(posedge ref_clk);
    end
    stall <= 1'b1;
    @(negedge ref_clk);
    check("taken", nTaken, 8'h10);
    check("drained", mAwValid, 1'b0);
    @(posedge ref_clk);
    push(rows[5].p, 1'b1, 1'b0);
    check("corrected", mAw, rows[5].p);
    check("single", singleErr, 1'b1);
    @(posedge ref_clk);
    pop();
    push(rows[9].p, 1'b0, 1'b1);
    check("double", doubleErr, 1'b1);
    check("nosingle", singleErr, 1'b0);
    @(posedge ref_clk);
    pop();
    avs(1'b0, REG_ERRORS, 32'h0);
    check("errors", q[1:0], 2'h3);
    avs(1'b1, REG_ERRORS, 32'h3);
    avs(1'b0, REG_ERRORS, 32'h0);
    check("cleared", q[1:0], 2'h0);
    avs(1'b1, REG_CTRL, 32'h0);
    avs(1'b0, REG_CTRL, 32'h0);
    check("ctrlOff", q, 32'h0);
    push(rows[3].p, 1'b1, 1'b1);
    check("plain", mAw, rows[3].p);
    check("noSingle", singleErr, 1'b0);
    check("noDouble", doubleErr, 1'b0);
    @(posedge ref_clk);
    // Second reset with new thresholds, taken on the first edge after release
    rst_n <= 1'b0;
    afThr <= 4'h1;
    aeThr <= 4'h0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    check("resetFill", cFill, 5'h00);
    check("resetValid", mAwValid, 1'b0);
    @(posedge ref_clk);
    avs(1'b0, REG_CTRL, 32'h0);
    check("ctrlReset", q, {31'h0, ECC_EN_RESET});
    push(rows[0].p, 1'b0, 1'b0);
    check("thrFull", af, 1'b1);
    check("thrEmpty", ae, 1'b0);
    give_verdict();
  end
endmodule

bind aw_queue_read_side aw_queue_read_side_asserts aw_queue_read_side_asserts_i (.ref_clk, .rst_n, .wrValid,
  .wrReady, .mAwValid, .mAwReady, .mAw, .almostFullThr, .almostEmptyThr, .singleErr, .doubleErr,
  .addr_queue_write_refused, .addr_queue_read_refused, .addr_queue_write_side_fill, .addr_queue_read_side_fill,
  .addr_queue_common_fill, .addr_queue_almost_full_flag, .addr_queue_almost_empty_flag);
